// [rtl/dcs_sequencer.sv]
// Per-channel DMA cycle sequencer with one memory master port
`timescale 1ns/100ps

// How it works
// - Finished cycle writes cycle type 000 back, so it never repeats.
// - Basic: each request moves exactly one item.
// - Basic: zero remaining raises interrupt, else rearbitrate and await request.
// - Autorequest: one request completes the whole cycle.
// - Autorequest: min(2^exponent, remaining) per turn, then internal request.
// - Ping-pong alternates structures until invalid one fetched or channel disabled.
// - Ping-pong halves act as basic; interrupt at each half's end.
// - Memory scatter-gather: four primary loads, then autorequest-like alternate, repeat.
// - Memory scatter-gather rearbitrates after each primary transfer, no new requests.
// - Scatter-gather ends on loaded basic or invalid structure; interrupt after basic.
// - Peripheral scatter-gather: four loads then alternate cycle, no rearbitration.
// - Peripheral scatter-gather waits for a peripheral request before next loads.
// - Source address is end pointer minus count shifted by increment; 3 fixed.
// - Destination address is end pointer minus count shifted by increment; 3 fixed.
// - Enable-clear bit aborts channel; software must not zero the configuration.
// - Count field bits 13:4 holds transfers minus one.
// - Control word written back with updated count before each arbitration.
module dcs_sequencer #(
  parameter int          N_CH       = 8,
  parameter logic [31:0] ALT_OFFSET = dcs_pkg::ALT_BASE_OFS
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // Requests and channel control
  input  wire logic [N_CH-1:0] dma_req,
  input  wire logic [N_CH-1:0] sw_req,
  input  wire logic [N_CH-1:0] prio_high,
  input  wire logic [N_CH-1:0] channel_enable_set,
  input  wire logic [N_CH-1:0] channel_enable_clear,
  input  wire logic [N_CH-1:0] alt_select_set,
  input  wire logic [31:0]     ctrl_base_ptr,
  // Memory master port
  output logic                 mem_req,
  output logic                 mem_we,
  output logic [31:0]          mem_addr,
  output logic [31:0]          mem_wdata,
  input  wire logic [31:0]     mem_rdata,
  input  wire logic            mem_ack,
  // Status
  output logic [N_CH-1:0]      done_irq,
  output logic [N_CH-1:0]      chan_enabled,
  output logic [N_CH-1:0]      chan_alt,
  output logic [6:0]           seq_state
);

  localparam int CW = (N_CH > 1) ? $clog2(N_CH) : 1;
  localparam int NL = dcs_pkg::N_LSB;
  localparam int NH = dcs_pkg::N_LSB + dcs_pkg::N_W - 1;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  dcs_pkg::dcs_state_t state, next_state;
  logic [CW-1:0]   ch, next_ch;
  logic [31:0]     ctrl, next_ctrl;
  logic [2:0]      mode, next_mode;
  logic [31:0]     src_end, next_src_end;
  logic [31:0]     dst_end, next_dst_end;
  logic [10:0]     burst, next_burst;
  logic            fin, next_fin;
  logic            blk, next_blk;
  logic [N_CH-1:0] en, next_en;
  logic [N_CH-1:0] alt, next_alt;
  logic [N_CH-1:0] pend, next_pend;
  logic [N_CH-1:0] apend, next_apend;
  logic [N_CH-1:0] next_irq;
  logic            next_mem_req;
  logic            next_mem_we;
  logic [31:0]     next_mem_addr;
  logic [31:0]     next_mem_wdata;

  logic [N_CH-1:0] take, aset, cand, hi, pool;
  logic [CW-1:0]   pick;
  logic            live;
  logic [dcs_pkg::N_W-1:0] n_cur, src_n;
  logic [31:0]     src_addr, dst_addr;

  assign n_cur = ctrl[NH:NL];
  // Next source address is needed while the count is still being decremented
  assign src_n = (state == dcs_pkg::S_WR_DATA) ? n_cur - dcs_pkg::N_ONE : n_cur;

  dcs_addr_gen u_src_addr (
    .end_ptr   (src_end),
    .inc       (ctrl[dcs_pkg::SOURCE_ADDRESS_INCREMENT_LSB +: 2]),
    .n_minus_1 (src_n),
    .addr      (src_addr)
  );

  dcs_addr_gen u_dst_addr (
    .end_ptr   (dst_end),
    .inc       (ctrl[dcs_pkg::DEST_ADDRESS_INCREMENT_LSB +: 2]),
    .n_minus_1 (n_cur),
    .addr      (dst_addr)
  );

  function automatic logic [31:0] struct_addr(input logic [CW-1:0] c, input logic a,
                                              input logic [31:0] ofs);
    logic [31:0] base;
    base = ctrl_base_ptr + ({{(32 - CW){1'b0}}, c} << dcs_pkg::STRUCT_SHIFT);
    struct_addr = (a ? base + ALT_OFFSET : base) + ofs;
  endfunction

  // Transfers per arbitration turn
  function automatic logic [10:0] burst_of(input logic [31:0] w);
    logic [2:0] cyc;
    logic [3:0] rp;
    cyc = w[dcs_pkg::CYC_LSB +: dcs_pkg::CYC_W];
    rp  = w[dcs_pkg::RPOW_LSB +: dcs_pkg::RPOW_W];
    case (cyc)
      dcs_pkg::CYC_BASIC, dcs_pkg::CYC_PINGPONG, dcs_pkg::CYC_PSG_ALT: begin
        burst_of = dcs_pkg::BURST_ONE;
      end
      dcs_pkg::CYC_MSG_PRI: begin
        burst_of = dcs_pkg::BURST_ONE;
      end
      default: begin
        burst_of = (rp >= dcs_pkg::RPOW_LIMIT) ? dcs_pkg::BURST_MAX
                                               : dcs_pkg::BURST_ONE << rp;
      end
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Arbitration: high-priority channels first, then lowest index
  // ------------------------------------------------------------------
  always_comb begin
    cand = (pend | apend) & en;
    hi   = cand & prio_high;
    pool = (|hi) ? hi : cand;
    pick = '0;
    for (int i = N_CH - 1; i >= 0; i--) begin
      if (pool[i]) begin
        pick = CW'(i);
      end
    end
  end

  // ------------------------------------------------------------------
  // Sequencer next state
  // ------------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_ch        = ch;
    next_ctrl      = ctrl;
    next_mode      = mode;
    next_src_end   = src_end;
    next_dst_end   = dst_end;
    next_burst     = burst;
    next_fin       = fin;
    next_blk       = blk;
    next_mem_req   = mem_ack ? 1'b0 : mem_req;
    next_mem_we    = mem_we;
    next_mem_addr  = mem_addr;
    next_mem_wdata = mem_wdata;
    next_alt       = alt | alt_select_set;
    next_irq       = '0;
    take           = '0;
    aset           = '0;
    // Clear wins over set: software owns the enable bit
    next_en = (en | channel_enable_set) & ~channel_enable_clear;
    live    = en[ch] & ~channel_enable_clear[ch];
    case (state)
      dcs_pkg::S_IDLE: begin
        if (|cand) begin
          next_ch       = pick;
          take[pick]    = 1'b1;
          next_state    = dcs_pkg::S_RD_CTRL;
          next_mem_req  = 1'b1;
          next_mem_we   = 1'b0;
          next_mem_addr = struct_addr(pick, alt[pick], dcs_pkg::OFS_CTRL);
        end
      end
      dcs_pkg::S_RD_CTRL: begin
        if (mem_ack) begin
          if (!live || mem_rdata[dcs_pkg::CYC_LSB +: dcs_pkg::CYC_W] == dcs_pkg::CYC_INVALID) begin
            next_state = dcs_pkg::S_IDLE;
          end else begin
            next_ctrl     = mem_rdata;
            next_mode     = mem_rdata[dcs_pkg::CYC_LSB +: dcs_pkg::CYC_W];
            next_burst    = burst_of(mem_rdata);
            next_state    = dcs_pkg::S_RD_SRC;
            next_mem_req  = 1'b1;
            next_mem_addr = struct_addr(ch, alt[ch], dcs_pkg::OFS_SRC_END);
          end
        end
      end
      dcs_pkg::S_RD_SRC: begin
        if (mem_ack) begin
          next_src_end  = mem_rdata;
          next_state    = live ? dcs_pkg::S_RD_DST : dcs_pkg::S_IDLE;
          next_mem_req  = live;
          next_mem_addr = struct_addr(ch, alt[ch], dcs_pkg::OFS_DST_END);
        end
      end
      dcs_pkg::S_RD_DST: begin
        if (mem_ack) begin
          next_dst_end  = mem_rdata;
          next_state    = live ? dcs_pkg::S_RD_DATA : dcs_pkg::S_IDLE;
          next_mem_req  = live;
          next_mem_addr = src_addr;
        end
      end
      dcs_pkg::S_RD_DATA: begin
        if (mem_ack) begin
          next_state     = live ? dcs_pkg::S_WR_DATA : dcs_pkg::S_IDLE;
          next_mem_req   = live;
          next_mem_we    = 1'b1;
          next_mem_addr  = dst_addr;
          next_mem_wdata = mem_rdata;
        end
      end
      dcs_pkg::S_WR_DATA: begin
        if (mem_ack) begin
          next_mem_we = 1'b0;
          next_fin    = (n_cur == '0);
          // A scatter-gather load block ends every fourth primary transfer
          next_blk    = (mode == dcs_pkg::CYC_MSG_PRI || mode == dcs_pkg::CYC_PSG_PRI) &&
                        (n_cur[1:0] == 2'h0);
          if (n_cur == '0) begin
            next_ctrl[dcs_pkg::CYC_LSB +: dcs_pkg::CYC_W] = dcs_pkg::CYC_INVALID;
          end else begin
            next_ctrl[NH:NL] = n_cur - dcs_pkg::N_ONE;
          end
          if (!live) begin
            next_state = dcs_pkg::S_IDLE;
          end else if (n_cur != '0 && !next_blk && burst > dcs_pkg::BURST_ONE) begin
            next_burst    = burst - dcs_pkg::BURST_ONE;
            next_state    = dcs_pkg::S_RD_DATA;
            next_mem_req  = 1'b1;
            next_mem_addr = src_addr;
          end else begin
            next_state     = dcs_pkg::S_WR_CTRL;
            next_mem_req   = 1'b1;
            next_mem_we    = 1'b1;
            next_mem_addr  = struct_addr(ch, alt[ch], dcs_pkg::OFS_CTRL);
            next_mem_wdata = next_ctrl;
          end
        end
      end
      dcs_pkg::S_WR_CTRL: begin
        if (mem_ack) begin
          next_mem_we = 1'b0;
          next_state  = dcs_pkg::S_IDLE;
          if (!live) begin
            next_state = dcs_pkg::S_IDLE;
          end else if (blk) begin
            next_alt[ch] = 1'b1;
            if (mode == dcs_pkg::CYC_PSG_PRI) begin
              // Alternate cycle starts at once, no arbitration in between
              next_state    = dcs_pkg::S_RD_CTRL;
              next_mem_req  = 1'b1;
              next_mem_addr = struct_addr(ch, 1'b1, dcs_pkg::OFS_CTRL);
            end else begin
              aset[ch] = 1'b1;
            end
          end else if (fin) begin
            case (mode)
              dcs_pkg::CYC_BASIC, dcs_pkg::CYC_AUTO: begin
                next_irq[ch] = 1'b1;
              end
              dcs_pkg::CYC_PINGPONG: begin
                next_irq[ch] = 1'b1;
                next_alt[ch] = ~alt[ch];
              end
              dcs_pkg::CYC_MSG_ALT: begin
                next_alt[ch] = 1'b0;
                aset[ch]     = 1'b1;
              end
              dcs_pkg::CYC_PSG_ALT: begin
                next_alt[ch] = 1'b0;
              end
              default: begin
                next_alt[ch] = alt[ch];
              end
            endcase
          end else if (mode == dcs_pkg::CYC_AUTO || mode == dcs_pkg::CYC_MSG_ALT ||
                       mode == dcs_pkg::CYC_MSG_PRI) begin
            aset[ch] = 1'b1;
          end
        end
      end
      default: begin
        next_state   = dcs_pkg::S_IDLE;
        next_mem_req = 1'b0;
      end
    endcase
    // New requests survive the cycle in which an old one is taken
    // A software select in the cycle of a hardware switch-back must not be lost
    next_alt   = next_alt | alt_select_set;
    next_pend  = (pend & ~take) | dma_req | sw_req;
    next_apend = (apend & ~take) | aset;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= dcs_pkg::S_IDLE;
      ch        <= '0;
      ctrl      <= '0;
      mode      <= dcs_pkg::CYC_INVALID;
      src_end   <= '0;
      dst_end   <= '0;
      burst     <= '0;
      fin       <= 1'b0;
      blk       <= 1'b0;
      en        <= '0;
      alt       <= '0;
      pend      <= '0;
      apend     <= '0;
      done_irq  <= '0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
    end else begin
      state     <= next_state;
      ch        <= next_ch;
      ctrl      <= next_ctrl;
      mode      <= next_mode;
      src_end   <= next_src_end;
      dst_end   <= next_dst_end;
      burst     <= next_burst;
      fin       <= next_fin;
      blk       <= next_blk;
      en        <= next_en;
      alt       <= next_alt;
      pend      <= next_pend;
      apend     <= next_apend;
      done_irq  <= next_irq;
      mem_req   <= next_mem_req;
      mem_we    <= next_mem_we;
      mem_addr  <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

  assign chan_enabled = en;
  assign chan_alt     = alt;
  assign seq_state    = state;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_psg_block_wb;
    state == dcs_pkg::S_WR_CTRL && mem_ack && live && blk && mode == dcs_pkg::CYC_PSG_PRI;
  endsequence
  sequence s_count_step;
    state == dcs_pkg::S_WR_DATA && mem_ack && live && n_cur != '0 ##1
    state == dcs_pkg::S_WR_CTRL;
  endsequence

  property p_fin_invalid;
    (state == dcs_pkg::S_WR_CTRL && mem_req && fin) |-> mem_wdata[2:0] == dcs_pkg::CYC_INVALID;
  endproperty
  a_fin_invalid: assert property (p_fin_invalid) else $error("finished cycle not invalidated");

  property p_basic_single;
    (state == dcs_pkg::S_WR_DATA && mem_ack && mode == dcs_pkg::CYC_BASIC) |=>
      state != dcs_pkg::S_RD_DATA;
  endproperty
  a_basic_single: assert property (p_basic_single) else $error("basic moved two items");

  property p_irq_cause;
    (|done_irq) |-> $past(state == dcs_pkg::S_WR_CTRL && mem_ack && fin);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without completion");

  property p_auto_rereq;
    (state == dcs_pkg::S_WR_CTRL && mem_ack && live && !fin && !blk &&
     mode == dcs_pkg::CYC_AUTO) |=> apend[ch] && state == dcs_pkg::S_IDLE;
  endproperty
  a_auto_rereq: assert property (p_auto_rereq) else $error("no internal request");

  property p_psg_direct;
    s_psg_block_wb |=> state == dcs_pkg::S_RD_CTRL && mem_req && alt[ch];
  endproperty
  a_psg_direct: assert property (p_psg_direct) else $error("alternate not started at once");

  property p_src_addr;
    (state == dcs_pkg::S_RD_DATA && mem_req && ctrl[27:26] != dcs_pkg::INC_FIXED) |->
      mem_addr == src_end - ({22'h00_0000, ctrl[13:4]} << ctrl[27:26]);
  endproperty
  a_src_addr: assert property (p_src_addr) else $error("source address wrong");

  property p_dst_addr;
    (state == dcs_pkg::S_WR_DATA && mem_req) |->
      mem_addr == ((ctrl[31:30] == dcs_pkg::INC_FIXED) ? dst_end :
                   dst_end - ({22'h00_0000, ctrl[13:4]} << ctrl[31:30]));
  endproperty
  a_dst_addr: assert property (p_dst_addr) else $error("destination address wrong");

  property p_count_wb;
    s_count_step |-> mem_wdata[13:4] == $past(ctrl[13:4]) - 10'h001;
  endproperty
  a_count_wb: assert property (p_count_wb) else $error("written-back count wrong");

  property p_abort_idle;
    (state != dcs_pkg::S_IDLE && !en[ch]) |-> ##[0:64] state == dcs_pkg::S_IDLE;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("aborted channel not idle");

  property p_abort_noirq;
    (state != dcs_pkg::S_IDLE && !en[ch]) |=> !(|done_irq);
  endproperty
  a_abort_noirq: assert property (p_abort_noirq) else $error("interrupt after abort");

endmodule

// [rtl/dcs_pkg.sv]
// Shared constants and types of the DMA cycle-type sequencer
package dcs_pkg;

  // ------------------------------------------------------------------
  // Cycle-type codes held in channel_control_word[2:0]
  // ------------------------------------------------------------------
  localparam logic [2:0] CYC_INVALID  = 3'h0;
  localparam logic [2:0] CYC_BASIC    = 3'h1;
  localparam logic [2:0] CYC_AUTO     = 3'h2;
  localparam logic [2:0] CYC_PINGPONG = 3'h3;
  localparam logic [2:0] CYC_MSG_PRI  = 3'h4;
  localparam logic [2:0] CYC_MSG_ALT  = 3'h5;
  localparam logic [2:0] CYC_PSG_PRI  = 3'h6;
  localparam logic [2:0] CYC_PSG_ALT  = 3'h7;

  // ------------------------------------------------------------------
  // Field layout of channel_control_word
  // ------------------------------------------------------------------
  localparam int DEST_ADDRESS_INCREMENT_LSB = 30;
  localparam int SOURCE_ADDRESS_INCREMENT_LSB = 26;
  localparam int RPOW_LSB    = 14;
  localparam int RPOW_W      = 4;
  localparam int N_LSB       = 4;
  localparam int N_W         = 10;
  localparam int CYC_LSB     = 0;
  localparam int CYC_W       = 3;

  localparam logic [1:0]     INC_FIXED  = 2'h3;
  localparam logic [N_W-1:0] N_ONE      = 10'h001;
  localparam logic [10:0]    BURST_ONE  = 11'h001;
  localparam logic [10:0]    BURST_MAX  = 11'h400;
  localparam logic [3:0]     RPOW_LIMIT = 4'hA;

  // ------------------------------------------------------------------
  // Control structure layout in system memory
  // ------------------------------------------------------------------
  localparam logic [31:0] OFS_SRC_END  = 32'h0000_0000;
  localparam logic [31:0] OFS_DST_END  = 32'h0000_0004;
  localparam logic [31:0] OFS_CTRL     = 32'h0000_0008;
  localparam int          STRUCT_SHIFT = 4;
  localparam logic [31:0] ALT_BASE_OFS = 32'h0000_0100;

  // ------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [6:0] {
    S_IDLE    = 7'h01,
    S_RD_CTRL = 7'h02,
    S_RD_SRC  = 7'h04,
    S_RD_DST  = 7'h08,
    S_RD_DATA = 7'h10,
    S_WR_DATA = 7'h20,
    S_WR_CTRL = 7'h40
  } dcs_state_t;

endpackage

// [rtl/dcs_addr_gen.sv]
// Address generator: end pointer minus remaining count scaled by increment
`timescale 1ns/100ps
module dcs_addr_gen (
  // Structure fields
  input  wire logic [31:0]              end_ptr,
  input  wire logic [1:0]               inc,
  input  wire logic [dcs_pkg::N_W-1:0]  n_minus_1,
  // Result
  output logic      [31:0]              addr
);

  logic [31:0] span;

  assign span = {{(32 - dcs_pkg::N_W){1'b0}}, n_minus_1} << inc;
  // Fixed address for peripheral data registers
  assign addr = (inc == dcs_pkg::INC_FIXED) ? end_ptr : end_ptr - span;

endmodule

// [testbench/dcs_mem_model.sv]
// System memory model answering the sequencer's master port
`timescale 1ns/100ps
module dcs_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Master port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack,
  // Wait cycles before each answer
  input  wire logic [3:0]  delay
);
  logic [31:0] ram [0:255];
  logic [3:0]  cnt;

  // Read data is inverted outside the ack cycle so a stale word never looks valid
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      mem_rdata <= 32'h0000_0000;
      cnt <= 4'h0;
    end else if (!mem_req || mem_ack) begin
      cnt <= 4'h0;
    end else if (cnt == delay) begin
      mem_ack <= 1'b1;
      if (mem_we)
        ram[mem_addr[9:2]] <= mem_wdata;
      else
        mem_rdata <= ram[mem_addr[9:2]];
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the DMA cycle-type sequencer
`timescale 1ns/100ps
module testbench;
  localparam int NC = 4;
  logic          clk;
  logic          rst;
  logic [NC-1:0] dma_req;
  logic [NC-1:0] sw_req;
  logic [NC-1:0] prio_high;
  logic [NC-1:0] en_set;
  logic [NC-1:0] en_clr;
  logic [NC-1:0] alt_set;
  logic          mem_req;
  logic          mem_we;
  logic          mem_ack;
  logic [31:0]   mem_addr;
  logic [31:0]   mem_wdata;
  logic [31:0]   mem_rdata;
  logic [NC-1:0] done_irq;
  logic [NC-1:0] chan_enabled;
  logic [NC-1:0] chan_alt;
  logic [6:0]    seq_state;
  logic [3:0]    delay;
  int            bad_count;
  int            checks;
  int            irqs;

  dcs_sequencer #(.N_CH(NC)) uut (
    .clk(clk), .rst(rst), .dma_req(dma_req), .sw_req(sw_req), .prio_high(prio_high),
    .channel_enable_set(en_set), .channel_enable_clear(en_clr), .alt_select_set(alt_set),
    .ctrl_base_ptr(32'h0000_0000), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .done_irq(done_irq), .chan_enabled(chan_enabled),
    .chan_alt(chan_alt), .seq_state(seq_state));

  dcs_mem_model mem (
    .clk(clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .delay(delay));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (!rst)
      irqs <= irqs + $countones(done_irq);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check32(input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  function automatic logic [31:0] cw(logic [1:0] si, logic [1:0] di, logic [3:0] rp,
                                     logic [9:0] n1, logic [2:0] cy);
    return {di, 2'h2, si, 2'h2, 6'h00, rp, n1, 1'b0, cy};
  endfunction

  task automatic put(input int a, input logic [31:0] s, input logic [31:0] d,
                     input logic [31:0] c);
    mem.ram[a/4] = s;
    mem.ram[a/4+1] = d;
    mem.ram[a/4+2] = c;
  endtask

  // Waits until the sequencer has sat idle for 8 cycles in a row
  task automatic settle();
    int idle;
    idle = 0;
    for (int i = 0; i < 20000 && idle < 8; i++) begin
      @(posedge clk);
      idle = (seq_state === dcs_pkg::S_IDLE) ? idle + 1 : 0;
    end
  endtask

  task automatic req(input int ch, input logic sw);
    @(posedge clk);
    if (sw)
      sw_req[ch] <= 1'b1;
    else
      dma_req[ch] <= 1'b1;
    @(posedge clk);
    sw_req <= '0;
    dma_req <= '0;
  endtask

  task automatic go(input int ch, input logic alt, input logic sw);
    @(posedge clk);
    en_set[ch] <= 1'b1;
    alt_set[ch] <= alt;
    @(posedge clk);
    en_set <= '0;
    alt_set <= '0;
    req(ch, sw);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_basic();
    put(32'h200, 32'hA5A5_0001, 32'hA5A5_0002, 32'h0);
    put(32'h000, 32'h204, 32'h304, cw(2'h2, 2'h2, 4'h0, 10'h001, dcs_pkg::CYC_BASIC));
    mem.ram[32'h304/4] = 32'h0;
    irqs = 0;
    go(0, 1'b0, 1'b0);
    settle();
    check32(32'hA5A5_0001, mem.ram[32'h300/4]);
    check32(32'h0, mem.ram[32'h304/4]);
    check32(cw(2'h2, 2'h2, 4'h0, 10'h000, dcs_pkg::CYC_BASIC), mem.ram[2]);
    check32(32'h0, irqs);
    req(0, 1'b0);
    settle();
    check32(32'hA5A5_0002, mem.ram[32'h304/4]);
    check32(32'h0, {29'h0, mem.ram[2][2:0]});
    check32(32'h1, irqs);
    $display("Test basic done");
  endtask

  task automatic t_auto();
    put(32'h010, 32'h208, 32'h31C, cw(2'h3, 2'h2, 4'h1, 10'h003, dcs_pkg::CYC_AUTO));
    mem.ram[32'h208/4] = 32'hC3C3_0003;
    mem.ram[32'h320/4] = 32'h0;
    delay = 4'h3;
    irqs = 0;
    go(1, 1'b0, 1'b1);
    settle();
    for (int i = 0; i < 4; i++)
      check32(32'hC3C3_0003, mem.ram[32'h310/4+i]);
    check32(32'h0, mem.ram[32'h320/4]);
    check32(32'h1, irqs);
    check32(32'h0, {29'h0, mem.ram[6][2:0]});
    delay = 4'h0;
    $display("Test autorequest done");
  endtask

  task automatic t_ping();
    // Both halves prepared before the first request
    put(32'h020, 32'h20C, 32'h330, cw(2'h2, 2'h2, 4'h0, 10'h000, dcs_pkg::CYC_PINGPONG));
    put(32'h120, 32'h210, 32'h334, cw(2'h2, 2'h2, 4'h0, 10'h000, dcs_pkg::CYC_PINGPONG));
    mem.ram[32'h20C/4] = 32'hD4D4_0004;
    mem.ram[32'h210/4] = 32'hE5E5_0005;
    irqs = 0;
    go(2, 1'b0, 1'b0);
    settle();
    check32(32'hD4D4_0004, mem.ram[32'h330/4]);
    check32(32'h1, irqs);
    check32(32'h1, {31'h0, chan_alt[2]});
    req(2, 1'b0);
    settle();
    check32(32'hE5E5_0005, mem.ram[32'h334/4]);
    check32(32'h2, irqs);
    check32(32'h0, {31'h0, chan_alt[2]});
    req(2, 1'b0);
    settle();
    check32(32'h2, irqs);
    $display("Test ping-pong done");
  endtask

  task automatic t_msg();
    put(32'h030, 32'h24C, 32'h13C, cw(2'h2, 2'h2, 4'h2, 10'h003, dcs_pkg::CYC_MSG_PRI));
    put(32'h240, 32'h214, 32'h340, cw(2'h2, 2'h2, 4'h0, 10'h000, dcs_pkg::CYC_BASIC));
    mem.ram[32'h24C/4] = 32'h0;
    mem.ram[32'h214/4] = 32'hF6F6_0006;
    irqs = 0;
    go(3, 1'b0, 1'b1);
    settle();
    check32(32'hF6F6_0006, mem.ram[32'h340/4]);
    check32(32'h1, irqs);
    check32(32'h0, {29'h0, mem.ram[32'h138/4][2:0]});
    $display("Test memory scatter-gather done");
  endtask

  task automatic t_psg();
    // Channel 1 in the high group must win over channel 0 asking in the same cycle
    @(posedge clk);
    prio_high <= 4'h2;
    dma_req <= 4'h3;
    @(posedge clk);
    dma_req <= '0;
    for (int i = 0; i < 8 && mem_req !== 1'b1; i++)
      @(posedge clk);
    check32(32'h18, mem_addr);
    settle();
    prio_high <= '0;
    put(32'h010, 32'h26C, 32'h11C, cw(2'h2, 2'h2, 4'h2, 10'h003, dcs_pkg::CYC_PSG_PRI));
    put(32'h260, 32'h21C, 32'h34C, cw(2'h2, 2'h2, 4'h0, 10'h001, dcs_pkg::CYC_BASIC));
    mem.ram[32'h26C/4] = 32'h0;
    mem.ram[32'h218/4] = 32'h1717_0007;
    mem.ram[32'h21C/4] = 32'h2828_0008;
    mem.ram[32'h34C/4] = 32'h0;
    irqs = 0;
    go(1, 1'b0, 1'b0);
    settle();
    check32(32'h1717_0007, mem.ram[32'h348/4]);
    check32(32'h0, mem.ram[32'h34C/4]);
    check32(32'h1, {31'h0, chan_alt[1]});
    check32(32'h0, irqs);
    req(1, 1'b0);
    settle();
    check32(32'h2828_0008, mem.ram[32'h34C/4]);
    check32(32'h1, irqs);
    check32(32'h0, {29'h0, mem.ram[32'h118/4][2:0]});
    check32(32'h0, {29'h0, mem.ram[6][2:0]});
    $display("Test peripheral scatter-gather done");
  endtask

  task automatic t_abort();
    // Full 1024-item count so the abort surely lands mid-cycle
    put(32'h000, 32'h200, 32'h3F0, cw(2'h3, 2'h3, 4'h0, 10'h3FF, dcs_pkg::CYC_AUTO));
    irqs = 0;
    go(0, 1'b0, 1'b1);
    repeat (40) @(posedge clk);
    en_clr[0] <= 1'b1;
    @(posedge clk);
    en_clr <= '0;
    settle();
    check32(32'h0, {31'h0, chan_enabled[0]});
    check32(32'h0, irqs);
    check32({29'h0, dcs_pkg::CYC_AUTO}, {29'h0, mem.ram[2][2:0]});
    $display("Test abort done");
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    {dma_req, sw_req, prio_high, en_set, en_clr, alt_set} = '0;
    delay = 4'h0;
    bad_count = 0;
    checks = 0;
    irqs = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_basic();
    t_auto();
    t_ping();
    t_msg();
    t_psg();
    t_abort();
    end_of_test();
  end

  // Whole run is well under a thousand cycles; far beyond that means a hang
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule
